// ===== core/iep_core.sv
/*
  Integrated endpoint core: config decode, BAR memory, MSI, PME, outbound path.
  Assumes requests and completions share core_clk; far side is the MMU port.
*/
// Notes on behaviour
// - PASID paths are at least 16 bits
// - PTM time taken from system counter
// - ECAM window hits become config requests
// - Bus and device numbers come from straps
// - Early vendor ID read answers retry status
// - Other early config reads return all ones
// - BAR readable, writable, reprogrammable at runtime
// - BAR decodes memory space only
// - Interrupts sent as MSI writes only
// - Inbound requests and completions stay ordered
// - Outbound writes leave in issue order
// - Reads never pass earlier writes
// - Pending bit clears after all reads complete
// - ATS capability present
// - PRI capability present
// - PASID presented as substream index
// - Stream index built from bus/device/function
// - Function level reset supported
// - Power states and PM capability supported
// - Wake sends PME to event collector
// - ACS present, violations logged through AER
// - Peer requests go through MMU checking
`timescale 1ns/10ps
`default_nettype none
module iep_core import iep_pkg::*; #(
  parameter int INIT_CYCLES = INIT_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] bus_num,
  input wire logic [4:0] dev_num,
  input wire logic crs_vis_en,
  input wire logic req_vld,
  output logic req_rdy,
  input wire iep_req_t req,
  output logic cpl_vld,
  input wire logic cpl_rdy,
  output var iep_cpl_t cpl,
  input wire logic dma_vld,
  output logic dma_rdy,
  input wire iep_dma_t dma,
  output logic out_vld,
  input wire logic out_rdy,
  output var iep_out_t out,
  input wire logic rd_done,
  input wire logic acs_err,
  input wire logic usr_irq,
  input wire logic usr_wake,
  input wire logic [63:0] sys_cnt,
  output logic [63:0] ptm_time,
  output logic [1:0] pwr_state,
  output logic trans_pend,
  output logic flr_pulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  iep_st_t st_ff;
  iep_cpl_t cpl_ff, nxt_cpl;
  iep_out_t out_ff, nxt_out;
  logic [12:0] bd_ff;
  logic flr_ff;
  logic [13:0] init_ff;
  logic [31:0] cmd_ff, bar_ff, pmcs_ff, msia_ff;
  logic [15:0] msid_ff;
  logic msien_ff, acsv_ff, irq_ff, pme_ff, out_vld_ff;
  logic [5:0] pend_ff;
  logic [63:0] ptm_ff;
  logic [31:0] wmask, rdat, mem_rd;
  logic [9:0] ridx;
  logic acc, cfg_hit, fn0, init_rdy, mem_hit, vid_rd, scr, use_mem;
  logic cfg_wr, ld, msi_go, dma_ok;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // Byte enables widened to a bit mask
  for (genvar i = 0; i < 4; i++) begin : g_be
    assign wmask[8*i+:8] = {8{req.be[i]}};
  end

  assign ridx = req.addr[11:2];
  assign fn0 = req.addr[14:12] == 3'h0;
  assign init_rdy = init_ff == 14'h0;
  assign acc = req_vld && req_rdy;
  assign cfg_hit = req.addr[31:28] == ECAM_HI && req.addr[27:15] == bd_ff;
  assign mem_hit = !cfg_hit && cmd_ff[B_MEM] && pmcs_ff[1:0] == D0
                   && req.addr[31:12] == bar_ff[31:12];
  assign vid_rd = !req.wr && ridx == R_ID && &req.be[1:0];
  assign scr = ridx[9:4] == R_SCR;
  assign use_mem = init_rdy && ((cfg_hit && fn0 && scr) || mem_hit);
  assign cfg_wr = acc && cfg_hit && fn0 && init_rdy && req.wr;

  // Merge written bytes into a field under a writable mask
  function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] m,
                                      logic [31:0] d, logic [31:0] wm);
    return (o & ~(m & wm)) | (d & m & wm);
  endfunction

  // Strap capture of bus and device number
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      bd_ff <= '0;
    else
      bd_ff <= {bus_num, dev_num};
  end

  // Function reset strobe and post-reset settle counter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flr_ff <= 1'b0;
      init_ff <= 14'(INIT_CYCLES);
    end else begin
      flr_ff <= cfg_wr && ridx == R_DCTL && req.data[B_FLR] && req.be[1];
      if (flr_ff)
        init_ff <= 14'(INIT_CYCLES);
      else if (!init_rdy)
        init_ff <= init_ff - 14'h1;
    end
  end

  // ----------------------------------------------------------------
  // Config registers
  // ----------------------------------------------------------------
  // Command and BAR, cleared by function reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_ff <= '0;
      bar_ff <= '0;
    end else if (flr_ff) begin
      cmd_ff <= '0;
      bar_ff <= '0;
    end else if (cfg_wr) begin
      if (ridx == R_CMD)
        cmd_ff <= mrg(cmd_ff, CMD_MSK, req.data, wmask);
      if (ridx == R_BAR)
        bar_ff <= mrg(bar_ff, BAR_MSK, req.data, wmask);
    end
  end

  // Power control: only D0 and D3 accepted, PME status write-one-clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      pmcs_ff <= '0;
    else if (flr_ff)
      pmcs_ff <= '0;
    else begin
      if (cfg_wr && ridx == R_PMCS && req.be[0]
          && (req.data[1:0] == D0 || req.data[1:0] == D3))
        pmcs_ff[1:0] <= req.data[1:0];
      if (cfg_wr && ridx == R_PMCS && req.be[1])
        pmcs_ff[B_PMEEN] <= req.data[B_PMEEN];
      if (usr_wake && pmcs_ff[B_PMEEN] && pmcs_ff[1:0] != D0)
        pmcs_ff[B_PMES] <= 1'b1;
      else if (cfg_wr && ridx == R_PMCS && req.be[1] && req.data[B_PMES])
        pmcs_ff[B_PMES] <= 1'b0;
    end
  end

  // MSI address, data and enable
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      msien_ff <= 1'b0;
      msia_ff <= '0;
      msid_ff <= '0;
    end else if (flr_ff) begin
      msien_ff <= 1'b0;
      msia_ff <= '0;
      msid_ff <= '0;
    end else if (cfg_wr) begin
      if (ridx == R_MSI && req.be[2])
        msien_ff <= req.data[B_MSIEN];
      if (ridx == R_MSIA)
        msia_ff <= mrg(msia_ff, 32'hffff_fffc, req.data, wmask);
      if (ridx == R_MSID)
        msid_ff <= 16'(mrg({16'h0, msid_ff}, 32'h0000_ffff, req.data, wmask));
    end
  end

  // ACS violation logged in AER status, write-one-clear, set wins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      acsv_ff <= 1'b0;
    else if (acs_err)
      acsv_ff <= 1'b1;
    else if (flr_ff || (cfg_wr && ridx == R_AERS && req.be[2] && req.data[B_ACSV]))
      acsv_ff <= 1'b0;
  end

  // Config read data
  always_comb begin
    unique case (ridx)
      R_ID: rdat = {DEV_ID, VEN_ID};
      R_CMD: rdat = STS_RV | cmd_ff;
      R_CLS: rdat = CLASS_RV;
      R_BAR: rdat = bar_ff;
      R_CAPP: rdat = CAP_PTR;
      R_PM: rdat = PM_HDR;
      R_PMCS: rdat = pmcs_ff;
      R_MSI: rdat = MSI_HDR | {15'h0, msien_ff, 16'h0};
      R_MSIA: rdat = msia_ff;
      R_MSID: rdat = {16'h0, msid_ff};
      R_PCIE: rdat = PCIE_HDR;
      R_DCAP: rdat = DCAP_RV;
      R_DCTL: rdat = {10'h0, trans_pend, 21'h0};
      R_AER: rdat = AER_HDR;
      R_AERS: rdat = {10'h0, acsv_ff, 21'h0};
      R_ACS: rdat = ACS_HDR;
      R_ATS: rdat = ATS_HDR;
      R_PRI: rdat = PRI_HDR;
      R_PAS: rdat = PAS_HDR;
      default: rdat = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Completion path
  // ----------------------------------------------------------------
  iep_mem u_mem (
    .core_clk(core_clk),
    .rstn(rstn),
    .we(acc && req.wr && use_mem),
    .re(acc && !req.wr && use_mem),
    .addr({mem_hit, cfg_hit ? ridx[3:0] : req.addr[5:2]}),
    .wdata(req.data),
    .wmask(wmask),
    .rdata(mem_rd)
  );

  // Completion status and data chosen at acceptance; store read data replaced from the store in S_MEM
  always_comb begin
    nxt_cpl = '{sts: ST_SC, data: '1};
    if (cfg_hit && !init_rdy) begin
      if (vid_rd && crs_vis_en)
        nxt_cpl.sts = ST_CRS;
    end else if (cfg_hit && !fn0)
      nxt_cpl.sts = ST_UR;
    else if (cfg_hit)
      nxt_cpl.data = req.wr ? 32'h0 : rdat;
    else if (!mem_hit)
      nxt_cpl.sts = ST_UR;
    else
      nxt_cpl.data = 32'h0;
  end

  // One request in flight; completion held until taken
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= S_IDLE;
      cpl_ff <= '0;
    end else begin
      unique case (st_ff)
        S_IDLE: if (acc) begin
          cpl_ff <= nxt_cpl;
          st_ff <= (use_mem && !req.wr) ? S_MEM : S_CPL;
        end
        S_MEM: begin
          cpl_ff.data <= mem_rd;
          st_ff <= S_CPL;
        end
        S_CPL: if (cpl_rdy)
          st_ff <= S_IDLE;
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  assign req_rdy = st_ff == S_IDLE;
  assign cpl_vld = st_ff == S_CPL;
  assign cpl = cpl_ff;

  // ----------------------------------------------------------------
  // Outbound path towards the MMU
  // ----------------------------------------------------------------
  assign ld = !out_vld_ff || out_rdy;
  assign msi_go = irq_ff && msien_ff && cmd_ff[B_BM];
  assign dma_ok = dma_vld && cmd_ff[B_BM] && pend_ff != PEND_MAX;
  assign dma_rdy = ld && !pme_ff && !msi_go && cmd_ff[B_BM] && pend_ff != PEND_MAX;

  // Pending interrupt and wake events, set wins over take
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
      pme_ff <= 1'b0;
    end else begin
      irq_ff <= usr_irq || (irq_ff && !(ld && !pme_ff && msi_go) && !flr_ff);
      pme_ff <= (usr_wake && pmcs_ff[B_PMEEN] && pmcs_ff[1:0] != D0)
                || (pme_ff && !ld);
    end
  end

  // Next outbound word: wake, then interrupt, then user traffic
  always_comb begin
    nxt_out = '0;
    nxt_out.sid = {bd_ff, 3'h0};
    nxt_out.wr = 1'b1;
    if (pme_ff) begin
      nxt_out.kind = K_PME;
      nxt_out.data = {24'h0, PME_CODE};
    end else if (msi_go) begin
      nxt_out.kind = K_MSI;
      nxt_out.addr = msia_ff;
      nxt_out.data = {16'h0, msid_ff};
    end else begin
      nxt_out.kind = K_MEM;
      nxt_out.wr = dma.wr;
      nxt_out.addr = dma.addr;
      nxt_out.data = dma.data;
      nxt_out.ssid = dma.pasid;
      nxt_out.pasid_vld = dma.pasid_vld;
      nxt_out.peer = dma.peer;
    end
  end

  // Single in-order stage keeps writes and later reads in issue order
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_vld_ff <= 1'b0;
      out_ff <= '0;
    end else if (ld) begin
      out_vld_ff <= pme_ff || msi_go || dma_ok;
      out_ff <= nxt_out;
    end
  end

  assign out_vld = out_vld_ff;
  assign out = out_ff;

  // Outstanding read count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      pend_ff <= '0;
    else if (dma_vld && dma_rdy && !dma.wr && !rd_done)
      pend_ff <= pend_ff + 6'h1;
    else if (rd_done && !(dma_vld && dma_rdy && !dma.wr) && pend_ff != 6'h0)
      pend_ff <= pend_ff - 6'h1;
  end

  // Time stamp source
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      ptm_ff <= '0;
    else
      ptm_ff <= sys_cnt;
  end

  assign trans_pend = pend_ff != 6'h0;
  assign ptm_time = ptm_ff;
  assign pwr_state = pmcs_ff[1:0];
  assign flr_pulse = flr_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cfg_id;
    acc && cfg_hit && fn0 && init_rdy && !req.wr && ridx == R_ID
    |=> cpl_vld && cpl.sts == ST_SC && cpl.data == {DEV_ID, VEN_ID};
  endproperty
  a_cfg_id: assert property (p_cfg_id) else $error("bad id read");
  property p_crs;
    acc && cfg_hit && !init_rdy && vid_rd && crs_vis_en |=> cpl_vld && cpl.sts == ST_CRS;
  endproperty
  a_crs: assert property (p_crs) else $error("no retry status");
  property p_ones;
    acc && cfg_hit && !init_rdy && !req.wr && !(vid_rd && crs_vis_en)
    |=> cpl.sts == ST_SC && cpl.data == 32'hffff_ffff;
  endproperty
  a_ones: assert property (p_ones) else $error("early read not ones");
  property p_bar;
    cfg_wr && ridx == R_BAR && &req.be && !flr_ff
    |=> bar_ff == ($past(req.data) & BAR_MSK);
  endproperty
  a_bar: assert property (p_bar) else $error("bar write wrong");
  property p_hold;
    cpl_vld && !cpl_rdy |=> cpl_vld && $stable(cpl) && !req_rdy;
  endproperty
  a_hold: assert property (p_hold) else $error("completion dropped");
  property p_tp;
    $fell(trans_pend) |-> $past(rd_done);
  endproperty
  a_tp: assert property (p_tp) else $error("pending cleared early");
  property p_sid;
    dma_vld && dma_rdy |=> out_vld && out.kind == K_MEM
      && out.sid == {$past(bd_ff), 3'h0} && out.peer == $past(dma.peer);
  endproperty
  a_sid: assert property (p_sid) else $error("bad stream index");
  property p_ssid;
    dma_vld && dma_rdy |=> out.ssid == $past(dma.pasid);
  endproperty
  a_ssid: assert property (p_ssid) else $error("bad substream index");
  property p_msi;
    ld && !pme_ff && msi_go |=> out_vld && out.kind == K_MSI && out.wr
      && out.data[15:0] == $past(msid_ff);
  endproperty
  a_msi: assert property (p_msi) else $error("msi not sent");
  property p_pme;
    usr_wake && pmcs_ff[B_PMEEN] && pmcs_ff[1:0] != D0 && !flr_ff
    |=> pme_ff && pmcs_ff[B_PMES];
  endproperty
  a_pme: assert property (p_pme) else $error("wake lost");
  property p_flr;
    flr_ff |=> bar_ff == 32'h0 && cmd_ff == 32'h0 && !init_rdy;
  endproperty
  a_flr: assert property (p_flr) else $error("function reset incomplete");
  c_crs: cover property (cpl_vld && cpl.sts == ST_CRS);
  c_msi: cover property (out_vld && out_rdy && out.kind == K_MSI);
  c_pme: cover property (out_vld && out_rdy && out.kind == K_PME);
  c_flr: cover property (flr_ff);
endmodule
`default_nettype wire

// ===== core/iep_mem.sv
/*
  Small word store behind the endpoint: scratch config dwords and BAR memory.
  Assumes one writer and one reader per cycle; read data appear one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
module iep_mem import iep_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic re,
  input wire logic [4:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] wmask,
  output logic [31:0] rdata
);
  logic [31:0] mem [MEM_WORDS];
  logic [31:0] rdata_ff;

  // Masked write
  always_ff @(posedge core_clk) begin
    if (we)
      mem[addr] <= (mem[addr] & ~wmask) | (wdata & wmask);
  end

  // Registered read
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      rdata_ff <= '0;
    else if (re)
      rdata_ff <= mem[addr];
  end

  assign rdata = rdata_ff;
endmodule
`default_nettype wire

// ===== core/iep_pkg.sv
/*
  Shared constants and types of the integrated endpoint core.
  Assumes a single 10 MHz core clock and an ECAM window in the second-highest 256 MB slot (address bits 31:28 = 0xE).
*/
package iep_pkg;
  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int INIT_NS = 1000000;
  localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PASID_W = 20;
  localparam int MEM_WORDS = 32;
  localparam logic [5:0] PEND_MAX = 6'h3f;
  // ----------------------------------------------------------------
  // Identity and decode
  // ----------------------------------------------------------------
  localparam logic [3:0] ECAM_HI = 4'he;
  localparam logic [15:0] VEN_ID = 16'h1234; // Arbitrary value
  localparam logic [15:0] DEV_ID = 16'h5678; // Arbitrary value
  localparam logic [31:0] CLASS_RV = 32'h0880_0000;
  localparam logic [31:0] CAP_PTR = 32'h0000_0040;
  localparam logic [31:0] BAR_MSK = 32'hffff_f000;
  localparam logic [31:0] CMD_MSK = 32'h0000_0006;
  localparam logic [31:0] STS_RV = 32'h0010_0000;
  // ----------------------------------------------------------------
  // Config dword indices
  // ----------------------------------------------------------------
  localparam logic [9:0] R_ID = 10'h000;
  localparam logic [9:0] R_CMD = 10'h001;
  localparam logic [9:0] R_CLS = 10'h002;
  localparam logic [9:0] R_BAR = 10'h004;
  localparam logic [9:0] R_CAPP = 10'h00d;
  localparam logic [9:0] R_PM = 10'h010;
  localparam logic [9:0] R_PMCS = 10'h011;
  localparam logic [9:0] R_MSI = 10'h014;
  localparam logic [9:0] R_MSIA = 10'h015;
  localparam logic [9:0] R_MSID = 10'h016;
  localparam logic [9:0] R_PCIE = 10'h018;
  localparam logic [9:0] R_DCAP = 10'h019;
  localparam logic [9:0] R_DCTL = 10'h01a;
  localparam logic [9:0] R_AER = 10'h040;
  localparam logic [9:0] R_AERS = 10'h041;
  localparam logic [9:0] R_ACS = 10'h050;
  localparam logic [9:0] R_ATS = 10'h060;
  localparam logic [9:0] R_PRI = 10'h070;
  localparam logic [9:0] R_PAS = 10'h080;
  localparam logic [5:0] R_SCR = 6'h03;
  // ----------------------------------------------------------------
  // Capability headers and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] PM_HDR = 32'h0003_5001;
  localparam logic [31:0] MSI_HDR = 32'h0000_6005;
  localparam logic [31:0] PCIE_HDR = 32'h0092_0010;
  localparam logic [31:0] DCAP_RV = 32'h1000_8020;
  localparam logic [31:0] AER_HDR = 32'h1401_0001;
  localparam logic [31:0] ACS_HDR = 32'h1801_000d;
  localparam logic [31:0] ATS_HDR = 32'h1c01_000f;
  localparam logic [31:0] PRI_HDR = 32'h2001_0013;
  localparam logic [31:0] PAS_HDR = 32'h0001_001b;
  localparam int B_MEM = 1;
  localparam int B_BM = 2;
  localparam int B_FLR = 15;
  localparam int B_TP = 21;
  localparam int B_PMEEN = 8;
  localparam int B_PMES = 15;
  localparam int B_MSIEN = 16;
  localparam int B_ACSV = 21;
  localparam logic [1:0] D0 = 2'h0;
  localparam logic [1:0] D3 = 2'h3;
  localparam logic [7:0] PME_CODE = 8'h18;
  localparam logic [1:0] ST_SC = 2'h0;
  localparam logic [1:0] ST_UR = 2'h1;
  localparam logic [1:0] ST_CRS = 2'h2;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {K_MEM = 2'b00, K_MSI = 2'b01, K_PME = 2'b10} iep_kind_t;
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_MEM = 2'b01, S_CPL = 2'b10} iep_st_t;
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } iep_req_t;
  typedef struct packed {
    logic [1:0] sts;
    logic [31:0] data;
  } iep_cpl_t;
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
    logic [31:0] data;
    logic [PASID_W-1:0] pasid;
    logic pasid_vld;
    logic peer;
  } iep_dma_t;
  typedef struct packed {
    iep_kind_t kind;
    logic wr;
    logic [31:0] addr;
    logic [31:0] data;
    logic [15:0] sid;
    logic [PASID_W-1:0] ssid;
    logic pasid_vld;
    logic peer;
  } iep_out_t;
endpackage

// ===== testbench/iep_core_bench.sv
/*
  Self-checking bench of the endpoint core with a random far-side model.
  Assumes a 100 ns clock and a shortened settle time after reset.
*/
`timescale 1ns/10ps
`default_nettype none
module iep_core_bench import iep_pkg::*; ;
  localparam int INIT = 60;
  logic core_clk, rstn, crs_vis_en, req_vld, req_rdy, cpl_vld, cpl_rdy, dma_vld, dma_rdy;
  logic out_vld, out_rdy, rd_done, acs_err, usr_irq, usr_wake, trans_pend, flr_pulse;
  logic [7:0] bus_num;
  logic [4:0] dev_num;
  logic [63:0] sys_cnt, ptm_time, x;
  logic [1:0] pwr_state;
  logic [31:0] v, w;
  logic [PASID_W-1:0] p;
  logic [9:0] cap_idx [7] = '{R_PM, R_MSI, R_AER, R_ACS, R_ATS, R_PRI, R_PAS};
  logic [7:0] cap_id [7] = '{8'h01, 8'h05, 8'h01, 8'h0d, 8'h0f, 8'h13, 8'h1b};
  iep_req_t req;
  iep_cpl_t cpl, c;
  iep_dma_t dma;
  iep_out_t out, o;
  iep_out_t oq [$];
  int num_errors, compares, flr_n;
  // ----------------------------------------------------------------
  // Design, far side, clock and monitors
  // ----------------------------------------------------------------
  iep_core #(.INIT_CYCLES(INIT)) iep_core_inst (.core_clk(core_clk), .rstn(rstn),
    .bus_num(bus_num), .dev_num(dev_num), .crs_vis_en(crs_vis_en), .req_vld(req_vld),
    .req_rdy(req_rdy), .req(req), .cpl_vld(cpl_vld), .cpl_rdy(cpl_rdy), .cpl(cpl),
    .dma_vld(dma_vld), .dma_rdy(dma_rdy), .dma(dma), .out_vld(out_vld), .out_rdy(out_rdy),
    .out(out), .rd_done(rd_done), .acs_err(acs_err), .usr_irq(usr_irq), .usr_wake(usr_wake),
    .sys_cnt(sys_cnt), .ptm_time(ptm_time), .pwr_state(pwr_state), .trans_pend(trans_pend),
    .flr_pulse(flr_pulse));
  iep_mmu_model iep_mmu_model_inst (.core_clk(core_clk), .rstn(rstn), .out_vld(out_vld),
    .out(out), .out_rdy(out_rdy), .rd_done(rd_done));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Counter feed, outbound capture and reset-pulse count
  always @(posedge core_clk) begin
    sys_cnt <= {$urandom, $urandom};
    if (out_vld && out_rdy) oq.push_back(out);
    if (flr_pulse) flr_n++;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] cfga(input logic [9:0] idx, input logic [2:0] fn);
    return {ECAM_HI, bus_num, dev_num, fn, idx, 2'b00};
  endfunction
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cfg(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    req_vld <= 1'b1;
    req <= '{wr, a, d, be};
    do @(posedge core_clk); while (!req_rdy);
    req_vld <= 1'b0;
    n = 0;
    forever begin
      @(posedge core_clk);
      n++;
      if ((cpl_vld && cpl_rdy) || n > 40) break;
      cpl_rdy <= 1'($urandom % 2);
    end
    c = cpl;
    if (n > 40) chk("completion wait", 64'h0, 64'h1);
    cpl_rdy <= 1'b0;
  endtask
  task automatic send(input logic wr, input logic [31:0] a, input logic [PASID_W-1:0] pa,
                      input logic peer);
    int n;
    dma_vld <= 1'b1;
    dma <= '{wr, a, $urandom, pa, 1'b1, peer};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!dma_rdy && n < 60);
    dma_vld <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pop();
    int n;
    n = 0;
    while (oq.size() == 0 && n < 80) begin
      @(posedge core_clk);
      n++;
    end
    o = '0;
    if (oq.size() == 0) chk("outbound word", 64'h1, 64'h0);
    else o = oq.pop_front();
  endtask
  // One-cycle event strobe: bit 0 interrupt, bit 1 wake, bit 2 peer violation
  task automatic pulse(input logic [2:0] m);
    {acs_err, usr_wake, usr_irq} <= m;
    @(posedge core_clk);
    {acs_err, usr_wake, usr_irq} <= 3'h0;
  endtask
  task close_out;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    close_out;
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'ha4d6));
    {rstn, req_vld, cpl_rdy, dma_vld, acs_err, usr_irq, usr_wake} = '0;
    {req, dma} = '0;
    crs_vis_en = 1'b1;
    bus_num = 8'($urandom);
    dev_num = 5'($urandom);
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk); // Straps reach the decode one edge after release
    cfg(0, cfga(R_ID, 0), 0, 4'hf);
    chk("early id status", ST_CRS, c.sts);
    crs_vis_en <= 1'b0;
    cfg(0, cfga(R_ID, 0), 0, 4'hf);
    chk("early id data", 32'hffff_ffff, c.data);
    crs_vis_en <= 1'b1;
    repeat (INIT) @(posedge core_clk);
    cfg(0, cfga(R_ID, 0), 0, 4'hf);
    chk("id", {ST_SC, DEV_ID, VEN_ID}, c);
    cfg(0, cfga(R_ID, 3'h1), 0, 4'hf);
    chk("absent fn", {ST_UR, 32'hffff_ffff}, c);
    foreach (cap_idx[i]) begin
      cfg(0, cfga(cap_idx[i], 0), 0, 4'hf);
      chk("cap id", cap_id[i], c.data[7:0]);
    end
    cfg(1, cfga(R_CMD, 0), CMD_MSK, 4'hf);
    repeat (2) begin
      v = {1'b0, 31'($urandom)};
      w = $urandom;
      cfg(1, cfga(R_BAR, 0), v, 4'hf);
      cfg(0, cfga(R_BAR, 0), 0, 4'hf);
      chk("bar", v & BAR_MSK, c.data);
      cfg(1, (v & BAR_MSK) | 32'h14, w, 4'hf);
      cfg(0, (v & BAR_MSK) | 32'h14, 0, 4'hf);
      chk("bar memory", w, c.data);
      cfg(0, (v & BAR_MSK) ^ 32'h0000_1000, 0, 4'hf);
      chk("outside bar", {ST_UR, 32'hffff_ffff}, c);
      cfg(1, cfga({R_SCR, 4'h5}, 0), v, 4'hf);
      cfg(0, cfga({R_SCR, 4'h5}, 0), 0, 4'hf);
      chk("scratch", v, c.data);
    end
    repeat (6) begin
      v = $urandom;
      p = PASID_W'($urandom) | 20'h80000;
      send(v[0], {v[31:2], 2'b00}, p, v[1]);
      send(1'b0, {v[31:2], 2'b00}, p, 1'b0);
      @(posedge core_clk);
      chk("pending", 1'b1, trans_pend);
      pop();
      chk("first word", {K_MEM, v[0], bus_num, dev_num, 3'h0, p, v[1]},
          {o.kind, o.wr, o.sid, o.ssid, o.peer});
      pop();
      chk("second word", 1'b0, o.wr);
    end
    repeat (20) @(posedge core_clk);
    chk("pending clear", 1'b0, trans_pend);
    v = $urandom & 32'hffff_fffc;
    w = {16'h0, 16'($urandom)};
    cfg(1, cfga(R_MSIA, 0), v, 4'hf);
    cfg(1, cfga(R_MSID, 0), w, 4'hf);
    pulse(3'h1);
    repeat (8) @(posedge core_clk);
    chk("msi held", 0, oq.size());
    cfg(1, cfga(R_MSI, 0), 32'h0001_0000, 4'hf);
    pop();
    chk("msi kind", {K_MSI, 1'b1}, {o.kind, o.wr});
    chk("msi word", {v, w}, {o.addr, o.data});
    cfg(1, cfga(R_PMCS, 0), 32'h0000_0103, 4'hf);
    @(posedge core_clk);
    chk("d state", D3, pwr_state);
    pulse(3'h2);
    pop();
    chk("pme", {K_PME, 24'h0, PME_CODE}, {o.kind, o.data});
    cfg(0, cfga(R_PMCS, 0), 0, 4'hf);
    chk("pme status", 1'b1, c.data[B_PMES]);
    pulse(3'h4);
    cfg(0, cfga(R_AERS, 0), 0, 4'hf);
    chk("acs logged", 1'b1, c.data[B_ACSV]);
    cfg(1, cfga(R_DCTL, 0), 32'h0000_8000, 4'h2);
    repeat (2) @(posedge core_clk);
    chk("flr pulse", 1, flr_n);
    cfg(0, cfga(R_CMD, 0), 0, 4'hf);
    chk("settling cmd", 32'hffff_ffff, c.data);
    repeat (INIT) @(posedge core_clk);
    cfg(0, cfga(R_CMD, 0), 0, 4'hf);
    chk("cmd after flr", {ST_SC, 32'h0}, {c.sts, c.data & CMD_MSK});
    chk("d state after flr", D0, pwr_state);
    @(posedge core_clk);
    x = sys_cnt;
    @(posedge core_clk);
    chk("ptm time", x, ptm_time);
    close_out;
  end
endmodule
`default_nettype wire

// ===== testbench/iep_mmu_model.sv
/*
  Far-side model of the translation port: takes outbound words, answers reads.
  Assumes the bench clock and active-low reset; stalls at random.
*/
`timescale 1ns/10ps
`default_nettype none
module iep_mmu_model import iep_pkg::*; (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic out_vld,
  input wire iep_out_t out,
  output logic out_rdy,
  output logic rd_done
);
  logic rdy_ff;
  logic [2:0] rd_ff;
  // Random back-pressure; words are taken strictly in arrival order
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) rdy_ff <= 1'b0;
    else rdy_ff <= 1'($urandom % 2);
  end
  // Each memory read taken is completed three cycles later
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) rd_ff <= 3'h0;
    else rd_ff <= {rd_ff[1:0], out_vld & rdy_ff & ~out.wr & (out.kind == K_MEM)};
  end
  assign out_rdy = rdy_ff;
  assign rd_done = rd_ff[2];
endmodule
`default_nettype wire
